//--- fctr_defines.vh
// Register map, field positions, reset values and codes of the timer
`ifndef FCTR_DEFINES_VH
`define FCTR_DEFINES_VH

// ----------------------------------------
// Word indices (byte address = 4 * index)
// ----------------------------------------
`define FCTR_WORD_STAT 6'h00
`define FCTR_WORD_CNTH 6'h01
`define FCTR_WORD_CNTL 6'h02
`define FCTR_WORD_MODH 6'h03
`define FCTR_WORD_MODL 6'h04
`define FCTR_WORD_CHSC 6'h05
`define FCTR_WORD_CHV 6'h09
`define FCTR_NUM_CH 6'h04

// ----------------------------------------
// Timer status and control fields
// ----------------------------------------
`define FCTR_ST_OVF 7
`define FCTR_ST_OVIE 6
`define FCTR_ST_HALT 5
`define FCTR_ST_CLR 4
`define FCTR_ST_PS_HI 2
`define FCTR_ST_PS_LO 0
`define FCTR_PS_EXT 3'h7

// ----------------------------------------
// Channel status and control fields
// ----------------------------------------
`define FCTR_CH_FLAG 7
`define FCTR_CH_IE 6
`define FCTR_CH_MSB 5
`define FCTR_CH_MSA 4
`define FCTR_CH_ELSB 3
`define FCTR_CH_ELSA 2
`define FCTR_CH_TOV 1
`define FCTR_CH_MAX 0
`define FCTR_CFG_MASK_ODD 7'h5F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FCTR_MOD_RESET 16'hFFFF
`define FCTR_CNT_RESET 16'h0000
`define FCTR_PS_RESET 3'h0
`define FCTR_CFG_RESET 7'h00

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define FCTR_RESP_OKAY 2'h0
`define FCTR_RESP_SLVERR 2'h2

`endif

//--- fctr_prescale.v
// Timer clock prescaler with external clock pin selection
`timescale 1ns/1ps
`include "fctr_defines.vh"

module fctr_prescale
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// Control
	input wire clear_in,
	input wire [2:0] sel_in,
	input wire ext_clk_in,
	// Timer clock enable
	output wire tick_out
);
	reg [5:0] div_r;
	reg ext_d_r;
	wire [5:0] mask;

	// ----------------------------------------
	// Divider and pin edge detect
	// ----------------------------------------
	assign mask = (6'h01 << sel_in) - 6'h01;
	assign tick_out = (sel_in == `FCTR_PS_EXT) ?
		(ext_clk_in & ~ext_d_r) : ((div_r & mask) == mask);

	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			div_r <= 6'h00;
			ext_d_r <= 1'b0;
		end
		else
		begin
			if (clear_in)
				div_r <= 6'h00;
			else
				div_r <= div_r + 6'h01;
			ext_d_r <= ext_clk_in;
		end
	end
endmodule

//--- fctr_channel.v
// One timer channel: capture, compare, event flag and pin drive
`timescale 1ns/1ps
`include "fctr_defines.vh"

module fctr_channel
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// Timebase
	input wire tick_in,
	input wire ovf_in,
	input wire halt_in,
	input wire [15:0] cnt_in,
	// Control
	input wire [6:0] cfg_in,
	input wire sc_rd_in,
	input wire sc_wr_in,
	input wire flag_wr_in,
	input wire [1:0] val_wr_in,
	input wire [15:0] val_data_in,
	// Pin
	input wire pin_in,
	output wire pin_out,
	output wire pin_oe_out,
	// Status
	output wire flag_out,
	output wire irq_out,
	output wire [15:0] val_out
);
	reg [15:0] val_r;
	reg flag_r;
	reg arm_r;
	reg pin_d_r;
	reg out_r;
	reg max_r;
	wire [1:0] els;
	wire msa;
	wire cmp_mode;
	wire tov;
	wire rise;
	wire fall;
	wire cap_ev;
	wire cmp_ev;
	wire ev;
	wire full;

	assign els = cfg_in[`FCTR_CH_ELSB:`FCTR_CH_ELSA];
	assign msa = cfg_in[`FCTR_CH_MSA];
	assign tov = cfg_in[`FCTR_CH_TOV];
	assign cmp_mode = cfg_in[`FCTR_CH_MSB] | msa;
	assign rise = pin_in & ~pin_d_r;
	assign fall = ~pin_in & pin_d_r;
	// Capture edges, blocked while halted
	assign cap_ev = ~cmp_mode & ~halt_in & (els != 2'b00) &
		((els[0] & rise) | (els[1] & fall));
	assign cmp_ev = cmp_mode & tick_in & (cnt_in == val_r);
	assign ev = cap_ev | cmp_ev;
	assign full = max_r & tov & (els == 2'b10);
	assign pin_oe_out = cmp_mode & (els != 2'b00);
	assign pin_out = out_r;
	assign flag_out = flag_r;
	assign irq_out = flag_r & cfg_in[`FCTR_CH_IE];
	assign val_out = val_r;

	// ----------------------------------------
	// Value register and event flag
	// ----------------------------------------
	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			val_r <= 16'h0000;
			flag_r <= 1'b0;
			arm_r <= 1'b0;
			pin_d_r <= 1'b0;
		end
		else
		begin
			pin_d_r <= pin_in;
			if (cap_ev)
				val_r <= cnt_in;
			else
			begin
				if (val_wr_in[0])
					val_r[7:0] <= val_data_in[7:0];
				if (val_wr_in[1])
					val_r[15:8] <= val_data_in[15:8];
			end
			if (ev)
				flag_r <= 1'b1;
			else if (sc_wr_in && !flag_wr_in && arm_r)
				flag_r <= 1'b0;
			if (ev || sc_wr_in)
				arm_r <= 1'b0;
			else if (sc_rd_in && flag_r)
				arm_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Output level
	// ----------------------------------------
	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			out_r <= 1'b1;
			max_r <= 1'b0;
		end
		else
		begin
			if (ovf_in)
				max_r <= cfg_in[`FCTR_CH_MAX];
			if (els == 2'b00)
				out_r <= ~msa;
			else if (cmp_mode && ovf_in && tov)
				out_r <= full | ~out_r;
			else if (cmp_ev)
			begin
				case (els)
				2'b01: out_r <= ~out_r;
				2'b10: out_r <= full;
				default: out_r <= 1'b1;
				endcase
			end
		end
	end
endmodule

//--- fctr_timer.v
// Four-channel timer: bus slave, counter, prescaler and channel array
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "fctr_defines.vh"

// Contract
// - Wrap at modulo sets overflow, restarts zero
// - Overflow clears by read then zero write
// - Overflow interrupt gated by enable, reset clears
// - Halt freezes counter; halt set at reset
// - Halt blocks channel input captures
// - Clear bit zeroes counter and prescaler
// - Halt with clear holds counter at zero
// - Prescale codes pick divider or pin
// - High read latches low byte once
// - Modulo high write blocks overflow until low
// - Modulo resets all ones, counter zero
// - Channel flag set by capture or compare
// - Channel flag clears by read then zero
// - Channel enable gates channel interrupt
// - Buffer bit disables partner channel 1/3
// - Low mode bit: mode or preset level
// - Edge bits 00 leave pin to port
// - Capture edge: rising, falling or both
// - Compare action toggle, clear or set
// - Overflow toggle wins over compare
// - Full-duty bit forces high next period
module fctr_timer
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	// AXI4-Lite write response
	output wire [1:0] s_axi_bresp_out,
	output wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0] s_axi_rresp_out,
	output wire s_axi_rvalid_out,
	input wire s_axi_rready_in,
	// Timer pins
	input wire external_timer_clock_in,
	input wire [3:0] ch_pin_in,
	output wire [3:0] ch_pin_out,
	output wire [3:0] ch_pin_oe_out,
	// Interrupt requests
	output wire ovf_irq_out,
	output wire [3:0] ch_irq_out
);
	// Bus state
	reg aw_hold_r;
	reg w_hold_r;
	reg [5:0] waddr_r;
	reg [15:0] wdata_r;
	reg [1:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg rvalid_r;
	reg [15:0] rdata_r;
	reg [1:0] rresp_r;
	// Timer state
	reg [15:0] cnt_r;
	reg [15:0] mod_r;
	reg mod_lock_r;
	reg [7:0] lo_buf_r;
	reg lo_latched_r;
	reg overflow_flag_r;
	reg ovf_arm_r;
	reg overflow_irq_enable_r;
	reg counter_halt_r;
	reg [2:0] prescale_select_r;
	reg [27:0] ch_cfg_r;
	// Read mux
	reg [15:0] rd_val;
	reg rd_hit;
	integer k;

	wire wr_go;
	wire ar_go;
	wire [5:0] raddr;
	wire w_stat;
	wire w_modh;
	wire w_modl;
	wire [5:0] wsc_off;
	wire [5:0] wv_off;
	wire [5:0] rsc_off;
	wire [5:0] rv_off;
	wire wsc_hit;
	wire wv_hit;
	wire rsc_hit;
	wire rv_hit;
	wire [3:0] wsc_sel;
	wire [3:0] wv_sel;
	wire [3:0] rsc_sel;
	wire clr_pls;
	wire tick;
	wire tick_g;
	wire ovf_wrap;
	wire ovf_set;
	wire [3:0] ch_dis;
	wire [27:0] ch_cfg_eff;
	wire [3:0] ch_flag;
	wire [63:0] ch_val;
	wire [31:0] sc_rd;
	wire [7:0] stat_rd;

	// ----------------------------------------
	// AXI4-Lite handshakes
	// ----------------------------------------
	assign s_axi_awready_out = ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready_out = ~w_hold_r & ~bvalid_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign s_axi_arready_out = ~rvalid_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rresp_out = rresp_r;
	assign s_axi_rdata_out = {16'h0000, rdata_r};
	assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
	assign ar_go = s_axi_arvalid_in & ~rvalid_r;
	assign raddr = s_axi_araddr_in[7:2];

	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			waddr_r <= 6'h00;
			wdata_r <= 16'h0000;
			wstrb_r <= 2'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `FCTR_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_hold_r <= 1'b1;
				waddr_r <= s_axi_awaddr_in[7:2];
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata_in[15:0];
				wstrb_r <= s_axi_wstrb_in[1:0];
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (wsc_hit || wv_hit ||
					waddr_r <= `FCTR_WORD_MODL) ?
					`FCTR_RESP_OKAY : `FCTR_RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready_in)
				bvalid_r <= 1'b0;
		end
	end

	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 16'h0000;
			rresp_r <= `FCTR_RESP_OKAY;
		end
		else if (ar_go)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_hit ? `FCTR_RESP_OKAY : `FCTR_RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready_in)
			rvalid_r <= 1'b0;
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign w_stat = wr_go & wstrb_r[0] & (waddr_r == `FCTR_WORD_STAT);
	assign w_modh = wr_go & wstrb_r[0] & (waddr_r == `FCTR_WORD_MODH);
	assign w_modl = wr_go & wstrb_r[0] & (waddr_r == `FCTR_WORD_MODL);
	assign wsc_off = waddr_r - `FCTR_WORD_CHSC;
	assign wv_off = waddr_r - `FCTR_WORD_CHV;
	assign rsc_off = raddr - `FCTR_WORD_CHSC;
	assign rv_off = raddr - `FCTR_WORD_CHV;
	assign wsc_hit = wsc_off < `FCTR_NUM_CH;
	assign wv_hit = wv_off < `FCTR_NUM_CH;
	assign rsc_hit = rsc_off < `FCTR_NUM_CH;
	assign rv_hit = rv_off < `FCTR_NUM_CH;
	assign wsc_sel = (wr_go & wsc_hit & wstrb_r[0]) ?
		(4'h1 << wsc_off[1:0]) : 4'h0;
	assign wv_sel = (wr_go & wv_hit) ? (4'h1 << wv_off[1:0]) : 4'h0;
	assign rsc_sel = (ar_go & rsc_hit) ? (4'h1 << rsc_off[1:0]) : 4'h0;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	assign stat_rd = {overflow_flag_r, overflow_irq_enable_r,
		counter_halt_r, 2'b00, prescale_select_r};

	always @*
	begin
		rd_val = 16'h0000;
		rd_hit = 1'b1;
		case (raddr)
		`FCTR_WORD_STAT: rd_val = {8'h00, stat_rd};
		`FCTR_WORD_CNTH: rd_val = {8'h00, cnt_r[15:8]};
		`FCTR_WORD_CNTL:
			rd_val = {8'h00, lo_latched_r ? lo_buf_r : cnt_r[7:0]};
		`FCTR_WORD_MODH: rd_val = {8'h00, mod_r[15:8]};
		`FCTR_WORD_MODL: rd_val = {8'h00, mod_r[7:0]};
		default:
		begin
			if (rsc_hit)
				rd_val = {8'h00, sc_rd[{rsc_off[1:0], 3'b000} +: 8]};
			else if (rv_hit)
				rd_val = ch_val[{rv_off[1:0], 4'h0} +: 16];
			else
				rd_hit = 1'b0;
		end
		endcase
	end

	// ----------------------------------------
	// Status and control, modulo
	// ----------------------------------------
	assign clr_pls = w_stat & wdata_r[`FCTR_ST_CLR];

	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			overflow_irq_enable_r <= 1'b0;
			counter_halt_r <= 1'b1;
			prescale_select_r <= `FCTR_PS_RESET;
			mod_r <= `FCTR_MOD_RESET;
			mod_lock_r <= 1'b0;
		end
		else
		begin
			if (w_stat)
			begin
				overflow_irq_enable_r <= wdata_r[`FCTR_ST_OVIE];
				counter_halt_r <= wdata_r[`FCTR_ST_HALT];
				prescale_select_r <=
					wdata_r[`FCTR_ST_PS_HI:`FCTR_ST_PS_LO];
			end
			if (w_modh)
			begin
				mod_r[15:8] <= wdata_r[7:0];
				mod_lock_r <= 1'b1;
			end
			if (w_modl)
			begin
				mod_r[7:0] <= wdata_r[7:0];
				mod_lock_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Overflow flag
	// ----------------------------------------
	assign ovf_set = ovf_wrap & ~mod_lock_r;
	assign ovf_irq_out = overflow_flag_r & overflow_irq_enable_r;

	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			overflow_flag_r <= 1'b0;
			ovf_arm_r <= 1'b0;
		end
		else
		begin
			if (ovf_set)
				overflow_flag_r <= 1'b1;
			else if (w_stat && !wdata_r[`FCTR_ST_OVF] && ovf_arm_r)
				overflow_flag_r <= 1'b0;
			if (ovf_set || w_stat)
				ovf_arm_r <= 1'b0;
			else if (ar_go && raddr == `FCTR_WORD_STAT && overflow_flag_r)
				ovf_arm_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Counter and read buffer
	// ----------------------------------------
	fctr_prescale u_prescale
	(
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.clear_in(clr_pls),
		.sel_in(prescale_select_r),
		.ext_clk_in(external_timer_clock_in),
		.tick_out(tick)
	);

	assign tick_g = tick & ~counter_halt_r;
	assign ovf_wrap = tick_g & (cnt_r == mod_r);

	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			cnt_r <= `FCTR_CNT_RESET;
			lo_buf_r <= 8'h00;
			lo_latched_r <= 1'b0;
		end
		else
		begin
			if (clr_pls)
				cnt_r <= `FCTR_CNT_RESET;
			else if (ovf_wrap)
				cnt_r <= `FCTR_CNT_RESET;
			else if (tick_g)
				cnt_r <= cnt_r + 16'h0001;
			if (clr_pls)
				lo_latched_r <= 1'b0;
			else if (ar_go && raddr == `FCTR_WORD_CNTH && !lo_latched_r)
			begin
				lo_buf_r <= cnt_r[7:0];
				lo_latched_r <= 1'b1;
			end
			else if (ar_go && raddr == `FCTR_WORD_CNTL)
				lo_latched_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Channel configuration
	// ----------------------------------------
	assign ch_dis = {ch_cfg_r[7 * 2 + `FCTR_CH_MSB], 1'b0,
		ch_cfg_r[`FCTR_CH_MSB], 1'b0};

	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			ch_cfg_r <= {4{`FCTR_CFG_RESET}};
		else
		begin
			for (k = 0; k < 4; k = k + 1)
			begin
				if (wsc_sel[k] && !ch_dis[k])
					ch_cfg_r[k * 7 +: 7] <= (k % 2 == 1) ?
						(wdata_r[6:0] & `FCTR_CFG_MASK_ODD) :
						wdata_r[6:0];
			end
		end
	end

	// ----------------------------------------
	// Channel array
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_ch
			assign ch_cfg_eff[i * 7 +: 7] =
				ch_dis[i] ? 7'h00 : ch_cfg_r[i * 7 +: 7];
			assign sc_rd[i * 8 +: 8] = ch_dis[i] ? 8'h00 :
				{ch_flag[i], ch_cfg_r[i * 7 +: 7]};

			fctr_channel u_ch
			(
				.clk_in(clk_in),
				.reset_n_in(reset_n_in),
				.tick_in(tick_g),
				.ovf_in(ovf_wrap),
				.halt_in(counter_halt_r),
				.cnt_in(cnt_r),
				.cfg_in(ch_cfg_eff[i * 7 +: 7]),
				.sc_rd_in(rsc_sel[i] & ~ch_dis[i]),
				.sc_wr_in(wsc_sel[i] & ~ch_dis[i]),
				.flag_wr_in(wdata_r[`FCTR_CH_FLAG]),
				.val_wr_in(wstrb_r & {2{wv_sel[i]}}),
				.val_data_in(wdata_r),
				.pin_in(ch_pin_in[i]),
				.pin_out(ch_pin_out[i]),
				.pin_oe_out(ch_pin_oe_out[i]),
				.flag_out(ch_flag[i]),
				.irq_out(ch_irq_out[i]),
				.val_out(ch_val[i * 16 +: 16])
			);
		end
	endgenerate
endmodule

//--- fctr_timer_sva.sv
// Concurrent checks on the timer's bus, pin and interrupt ports
`timescale 1ns/1ps

module fctr_timer_sva
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// Bus
	input wire [7:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	input wire s_axi_arready_out,
	input wire [31:0] s_axi_rdata_out,
	input wire [1:0] s_axi_rresp_out,
	input wire s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire s_axi_awready_out,
	input wire s_axi_wready_out,
	input wire [1:0] s_axi_bresp_out,
	input wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	// Pins and interrupts
	input wire [3:0] ch_pin_oe_out,
	input wire ovf_irq_out,
	input wire [3:0] ch_irq_out
);
reg [5:0] rd_word_r;

// Word of the read in flight
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
		rd_word_r <= 6'h00;
	else if (s_axi_arvalid_in && s_axi_arready_out)
		rd_word_r <= s_axi_araddr_in[7:2];
end

default clocking @(posedge clk_in); endclocking
default disable iff (!reset_n_in);

a_read_next: assert property (s_axi_arvalid_in && s_axi_arready_out
	|=> s_axi_rvalid_out) else $error("read answer late");
a_read_held: assert property (s_axi_rvalid_out && !s_axi_rready_in
	|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
	else $error("read data not held");
a_write_held: assert property (s_axi_bvalid_out && !s_axi_bready_in
	|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
	else $error("write response not held");
a_write_refused: assert property (s_axi_bvalid_out
	|-> !s_axi_awready_out && !s_axi_wready_out)
	else $error("write taken while response pending");
a_unmapped_read: assert property (s_axi_rvalid_out && rd_word_r >= 6'h0D
	|-> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h00000000)
	else $error("unmapped read not refused");
a_mapped_read: assert property (s_axi_rvalid_out && rd_word_r < 6'h0D
	|-> s_axi_rresp_out == 2'h0 && s_axi_rdata_out[31:16] == 16'h0000)
	else $error("mapped read bad response");
a_clear_reads_zero: assert property (
	s_axi_rvalid_out && rd_word_r == 6'h00 |-> s_axi_rdata_out[4:3] == 2'h0)
	else $error("clear bit read back");
a_ovf_irq_drop: assert property (
	$fell(ovf_irq_out) |-> $rose(s_axi_bvalid_out))
	else $error("overflow request dropped without write");
a_ch_irq_drop: assert property (
	|($past(ch_irq_out) & ~ch_irq_out) |-> $rose(s_axi_bvalid_out))
	else $error("channel request dropped without write");
a_oe_on_write: assert property (
	!$stable(ch_pin_oe_out) |-> $rose(s_axi_bvalid_out))
	else $error("pin enable changed without write");

c_ovf_irq: cover property ($rose(ovf_irq_out));
c_ch_irq: cover property ($rose(|ch_irq_out));
c_slverr: cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
endmodule

bind fctr_timer fctr_timer_sva u_sva (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .s_axi_araddr_in(s_axi_araddr_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .ch_pin_oe_out(ch_pin_oe_out),
	.ovf_irq_out(ovf_irq_out), .ch_irq_out(ch_irq_out));

//--- fctr_timer_tb.sv
// Self-checking bench for the four-channel timer register block
`timescale 1ns/1ps
`include "fctr_defines.vh"
`define CHECK_EQ(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	error_cnt++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end

module fctr_timer_tb;
localparam [7:0] A_ST = {`FCTR_WORD_STAT, 2'h0};
localparam [7:0] A_CH = {`FCTR_WORD_CNTH, 2'h0};
localparam [7:0] A_CL = {`FCTR_WORD_CNTL, 2'h0};
localparam [7:0] A_MH = {`FCTR_WORD_MODH, 2'h0};
localparam [7:0] A_ML = {`FCTR_WORD_MODL, 2'h0};
localparam [7:0] A_C0 = {`FCTR_WORD_CHSC, 2'h0};
localparam [7:0] A_C1 = {`FCTR_WORD_CHSC + 6'h01, 2'h0};
localparam [7:0] A_V1 = {`FCTR_WORD_CHV + 6'h01, 2'h0};
reg clk_in, reset_n_in, awv, wv, bready, arv, rready, ext_clk;
reg [7:0] awaddr, araddr, a;
reg [31:0] wdata, d;
reg [3:0] wstrb, pin_in;
reg [15:0] cnt, pre;
wire awready, wready, bvalid, arready, rvalid, ovf_irq;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [3:0] pin_out, pin_oe, ch_irq;
integer error_cnt, tests_run, c, ex;

fctr_timer u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
	.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
	.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wready),
	.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
	.s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
	.s_axi_arvalid_in(arv), .s_axi_arready_out(arready),
	.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
	.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
	.external_timer_clock_in(ext_clk), .ch_pin_in(pin_in),
	.ch_pin_out(pin_out), .ch_pin_oe_out(pin_oe), .ovf_irq_out(ovf_irq),
	.ch_irq_out(ch_irq));

initial
begin
	clk_in = 1'b0;
	forever #10 clk_in = ~clk_in;
end

task automatic cyc(input integer n);
	repeat (n) @(posedge clk_in);
endtask

task automatic wr(input [7:0] ad, input [15:0] dt);
	reg ta, tw;
	begin
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= ad;
		wdata <= {16'h0000, dt};
		awv <= 1'b1;
		wv <= 1'b1;
		while (!(ta && tw))
		begin
			@(posedge clk_in);
			if (!ta && awready)
			begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (!tw && wready)
			begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk_in); while (!bvalid);
		`CHECK_EQ("bresp", (ad >= 8'h34) ? 2'h2 : 2'h0, bresp)
	end
endtask

task automatic rd(input [7:0] ad, output [31:0] dt);
	begin
		araddr <= ad;
		arv <= 1'b1;
		do @(posedge clk_in); while (!arready);
		arv <= 1'b0;
		do @(posedge clk_in); while (!rvalid);
		dt = rdata;
		`CHECK_EQ("rresp", (ad >= 8'h34) ? 2'h2 : 2'h0, rresp)
	end
endtask

task automatic ck(input string nm, input [7:0] ad, input [31:0] e);
	reg [31:0] v;
	begin
		rd(ad, v);
		`CHECK_EQ(nm, e, v)
	end
endtask

task automatic rdcnt(output [15:0] v);
	reg [31:0] h, l;
	begin
		rd(A_CH, h);
		rd(A_CL, l);
		v = {h[7:0], l[7:0]};
	end
endtask

task automatic pulses(input integer n);
	repeat (n)
	begin
		ext_clk <= 1'b1;
		cyc(2);
		ext_clk <= 1'b0;
		cyc(2);
	end
endtask

// Arm with a status read, then write the flag to zero
task automatic clr0;
	begin
		rd(A_C0, d);
		wr(A_C0, {8'h00, d[7:0] & 8'h7F});
		`CHECK_EQ("ch_clr", 1'b0, ch_irq[0])
	end
endtask

task finish_test;
	begin
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
endtask

initial
begin
	cyc(40000);
	error_cnt++;
	$display("watchdog expired");
	finish_test;
end

initial
begin
	error_cnt = 0;
	tests_run = 0;
	reset_n_in = 1'b0;
	{awv, wv, arv, ext_clk} = 4'h0;
	{bready, rready} = 2'h3;
	{awaddr, araddr, wdata} = 48'h0;
	wstrb = 4'hF;
	pin_in = 4'h0;
	cyc(10);
	reset_n_in <= 1'b1;
	cyc(1);
	ck("status", A_ST, 32'h20);
	ck("cnt_hi", A_CH, 32'h0);
	ck("mod_hi", A_MH, 32'hFF);
	ck("mod_lo", A_ML, 32'hFF);
	for (a = A_C0; a <= A_C0 + 8'h0C; a = a + 8'h04)
		ck("ch_sc", a, 32'h0);
	ck("cnt_lo", A_CL, 32'h0);
	`CHECK_EQ("pins", 8'hF0, {pin_out, pin_oe})
	`CHECK_EQ("irqs", 5'h00, {ovf_irq, ch_irq})
	$display("test reset done");
	for (c = 0; c < 7; c++)
	begin
		wr(A_ST, 16'h0030);
		wr(A_ST, {13'h0000, c[2:0]});
		cyc(256);
		wr(A_ST, {8'h00, 5'h04, c[2:0]});
		rdcnt(cnt);
		ex = 258 >> c;
		`CHECK_EQ("ps_cnt", 1'b1, cnt + 3 >= ex && cnt <= ex + 3)
	end
	cyc(100);
	rd(A_CL, d);
	`CHECK_EQ("halted", cnt[7:0], d[7:0])
	wr(A_ST, 16'h0030);
	cyc(8);
	ck("clr_cnt", A_CL, 32'h0);
	ck("clr_rd", A_ST, 32'h20);
	wr(A_ST, 16'h0007);
	pulses(10);
	wr(A_ST, 16'h0027);
	rdcnt(cnt);
	`CHECK_EQ("ext_cnt", 16'h000A, cnt)
	rd(A_CH, d);
	wr(A_ST, 16'h0007);
	pulses(5);
	wr(A_ST, 16'h0027);
	rd(A_CH, d);
	ck("latched", A_CL, 32'h0A);
	wr(A_CL, 16'h0055);
	ck("live", A_CL, 32'h0F);
	$display("test prescale done");
	wr(A_ST, 16'h0030);
	wr(A_MH, 16'h0000);
	wr(A_ML, 16'h000F);
	wr(A_ST, 16'h0040);
	cyc(40);
	wr(A_ST, 16'h0060);
	rdcnt(cnt);
	`CHECK_EQ("wrap", 1'b1, cnt <= 16'h000F)
	ck("ovf_set", A_ST, 32'hE0);
	wr(A_ST, 16'h00A0);
	`CHECK_EQ("ovf_mask", 1'b0, ovf_irq)
	wr(A_ST, 16'h00E0);
	ck("ovf_keep", A_ST, 32'hE0);
	wr(A_ST, 16'h00E0);
	`CHECK_EQ("ovf_w1", 1'b1, ovf_irq)
	ck("ovf_arm", A_ST, 32'hE0);
	wr(A_ST, 16'h0060);
	`CHECK_EQ("ovf_clr", 1'b0, ovf_irq)
	wr(A_MH, 16'h0000);
	wr(A_ST, 16'h0040);
	cyc(60);
	`CHECK_EQ("mod_lock", 1'b0, ovf_irq)
	wr(A_ML, 16'h000F);
	cyc(40);
	`CHECK_EQ("mod_unlock", 1'b1, ovf_irq)
	wr(A_ST, 16'h0030);
	wr(A_MH, 16'h00FF);
	wr(A_ML, 16'h00FF);
	$display("test overflow done");
	wr(A_ST, 16'h0000);
	for (c = 1; c < 4; c++)
	begin
		wr(A_C0, {8'h00, 4'h4, c[1:0], 2'h0});
		pin_in[0] <= 1'b1;
		cyc(4);
		`CHECK_EQ("rise", c[0], ch_irq[0])
		clr0();
		pin_in[0] <= 1'b0;
		cyc(4);
		`CHECK_EQ("fall", c[1], ch_irq[0])
		clr0();
	end
	pin_in[0] <= 1'b1;
	cyc(4);
	ck("ch_set", A_C0, 32'hCC);
	wr(A_C0, 16'h00CC);
	`CHECK_EQ("ch_w1", 1'b1, ch_irq[0])
	wr(A_C0, 16'h000C);
	`CHECK_EQ("ch_mask", 1'b0, ch_irq[0])
	ck("ch_kept", A_C0, 32'h8C);
	wr(A_C0, 16'h000C);
	ck("ch_cleared", A_C0, 32'h0C);
	wr(A_ST, 16'h0020);
	pin_in[0] <= 1'b0;
	cyc(4);
	ck("halt_cap", A_C0, 32'h0C);
	$display("test capture done");
	wr(A_V1, 16'h0005);
	for (c = 0; c < 4; c++)
	begin
		wr(A_ST, 16'h0030);
		pre = (c == 0 || c == 3) ? 16'h0010 : 16'h0000;
		wr(A_C1, pre);
		cyc(1);
		`CHECK_EQ("preset", pre[4], ~pin_out[1])
		wr(A_C1, {8'h00, 4'h1, c[1:0], 2'h0});
		wr(A_ST, 16'h0000);
		cyc(20);
		wr(A_ST, 16'h0020);
		`CHECK_EQ("cmp_pin", c == 3, pin_out[1])
		`CHECK_EQ("cmp_oe", c != 0, pin_oe[1])
		rd(A_C1, d);
		`CHECK_EQ("cmp_flag", 1'b1, d[7])
	end
	wr(A_C0, 16'h002C);
	ck("partner", A_C1, 32'h0);
	`CHECK_EQ("partner_oe", 1'b0, pin_oe[1])
	wr(A_C0, 16'h0000);
	`CHECK_EQ("partner_back", 1'b1, pin_oe[1])
	wr(A_ST, 16'h0030);
	wr(A_MH, 16'h0000);
	wr(A_ML, 16'h000F);
	wr(A_C1, 16'h001A);
	wr(A_ST, 16'h0000);
	cyc(31);
	wr(A_ST, 16'h0020);
	`CHECK_EQ("ovf_toggle", 1'b1, pin_out[1])
	wr(A_ST, 16'h0030);
	wr(A_C1, 16'h001B);
	wr(A_ST, 16'h0000);
	cyc(40);
	wr(A_ST, 16'h0020);
	`CHECK_EQ("full_duty", 1'b1, pin_out[1])
	ck("unmapped", 8'h34, 32'h0);
	wr(8'h3C, 16'h1234);
	$display("test compare done");
	finish_test;
end
endmodule
